// [rtl/dbgbrk_pkg.sv]
/*
 * Package for the debug register access front end: register select codes,
 * field positions, reset values and enumerations.
 * Assumes a single 125 MHz processor clock shared by the whole block.
 */
package dbgbrk_pkg;

    localparam int unsigned DBGBRK_NUM_REGS  = 19;
    localparam int unsigned DBGBRK_SEL_W     = 5;
    localparam int unsigned DBGBRK_DATA_W    = 32;

    // Register select codes
    localparam logic [4:0] SEL_CONFIG_STATUS = 5'h00;
    localparam logic [4:0] SEL_SPACE_CONTROL = 5'h08;
    localparam logic [4:0] SEL_ACCESS_ATTR   = 5'h05;
    localparam logic [4:0] SEL_ATTR_TRIG     = 5'h06;
    localparam logic [4:0] SEL_TRIG_DEF      = 5'h07;
    localparam logic [4:0] SEL_ATTR_TRIG_2   = 5'h16;

    // Configuration/status fields
    localparam int unsigned CS_STATUS_LSB    = 24;
    localparam int unsigned CS_STATUS_W      = 4;
    localparam int unsigned CS_INHIBIT_BIT   = 22;
    localparam logic [31:0] CS_WRITE_MASK    = 32'h00FF_FFFF;

    // Access attribute fields
    localparam int unsigned ATTR_DIR_BIT     = 7;
    localparam int unsigned ATTR_SIZE_LSB    = 5;
    localparam logic [7:0]  ATTR_RESET       = 8'h05;
    localparam logic [7:0]  ATTR_TYPE_MASK   = 8'h1F;

    // Address attribute trigger: space id field and its enable bit
    localparam int unsigned AAT_SPACE_ID_LSB = 16;
    localparam int unsigned AAT_SPACE_EN_BIT = 31;

    // Trigger definition fields
    localparam int unsigned TD_RESP_LSB      = 30;
    localparam int unsigned TD_L2_LSB        = 16;
    localparam int unsigned TD_ENABLE_BIT    = 13;
    localparam int unsigned TD_DATA_EN_LSB   = 6;
    localparam int unsigned TD_ADDR_EN_LSB   = 2;

    localparam int unsigned NUM_PC_BREAKS    = 4;
    localparam int unsigned PC_QUAL_W        = 4;

    typedef enum logic [1:0] {
        DBGBRK_RESP_TRACE = 2'h0,
        DBGBRK_RESP_HALT  = 2'h1,
        DBGBRK_RESP_IRQ   = 2'h2,
        DBGBRK_RESP_RSVD  = 2'h3
    } dbgbrk_resp_t;

endpackage

// [rtl/dbgbrk_regs.sv]
/*
 * Debug register file and breakpoint configuration front end.
 * Assumes the core write port and the serial debug port are already decoded
 * into one-cycle strobes, and that both never write in the same cycle.
 */
`timescale 1ns/1ps

module dbgbrk_regs
    import dbgbrk_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        core_write,
    input  wire logic [4:0]  core_select,
    input  wire logic [31:0] core_data,
    input  wire logic        port_write,
    input  wire logic        port_read,
    input  wire logic [4:0]  port_select,
    input  wire logic [31:0] port_data,
    input  wire logic        mem_command,
    input  wire logic        mem_is_read,
    input  wire logic [1:0]  mem_size,
    input  wire logic        trigger_event,
    input  wire logic [3:0]  trigger_status_in,
    output logic [31:0]      port_read_data,
    output logic             port_read_valid,
    output logic [31:0]      config_status,
    output logic [7:0]       access_attribute,
    output logic [31:0]      attr_trigger,
    output logic [31:0]      attr_trigger_second,
    output logic [31:0]      trigger_definition,
    output logic [15:0]      pc_space_control,
    output logic             level1_addr_enabled,
    output logic             level2_addr_enabled,
    output logic             level1_data_enabled,
    output logic             level2_data_enabled,
    output logic             attr_space_match_en,
    output logic             attr2_space_match_en,
    output logic [1:0]       response_select
);

    typedef struct packed {
        logic [31:0] cfg;
        logic [7:0]  attr;
        logic [31:0] aat;
        logic [31:0] aat2;
        logic [31:0] tdef;
        logic [15:0] pc_breakpoint_space_control;
        logic [31:0] rdata;
        logic        rvalid;
    } dbgbrk_state_t;

    dbgbrk_state_t state;
    dbgbrk_state_t next_state;

    logic        wr;
    logic [4:0]  wsel;
    logic [31:0] wdata;
    logic        core_blocked;

    // Core write loses to the lock; port writes never locked
    assign core_blocked = core_write && state.cfg[CS_INHIBIT_BIT];
    assign wr    = port_write || (core_write && !core_blocked);
    assign wsel  = port_write ? port_select : core_select;
    assign wdata = port_write ? port_data : core_data;

    always_comb begin
        next_state = state;
        next_state.rvalid = 1'b0;
        if (trigger_event) begin
            next_state.cfg[CS_STATUS_LSB +: CS_STATUS_W] = trigger_status_in;
        end
        if (wr) begin
            unique case (wsel)
                SEL_CONFIG_STATUS: begin
                    next_state.cfg = (state.cfg & ~CS_WRITE_MASK) | (wdata & CS_WRITE_MASK);
                end
                SEL_SPACE_CONTROL: begin
                    next_state.pc_breakpoint_space_control = wdata[15:0];
                end
                SEL_ACCESS_ATTR: begin
                    next_state.attr = (state.attr & ~ATTR_TYPE_MASK) | (wdata[7:0] & ATTR_TYPE_MASK);
                end
                SEL_ATTR_TRIG: begin
                    next_state.aat  = wdata;
                    next_state.attr = wdata[7:0];
                end
                SEL_ATTR_TRIG_2: begin
                    next_state.aat2 = wdata;
                end
                SEL_TRIG_DEF: begin
                    next_state.tdef = wdata;
                    if (!trigger_event) begin
                        next_state.cfg[CS_STATUS_LSB +: CS_STATUS_W] = '0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Memory command sets direction and size last
        if (mem_command) begin
            next_state.attr[ATTR_DIR_BIT] = mem_is_read;
            next_state.attr[ATTR_SIZE_LSB +: 2] = mem_size;
        end
        // Only config/status reads back; write-only ones read zero
        if (port_read) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = (port_select == SEL_CONFIG_STATUS) ? state.cfg : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state       <= '0;
            state.attr  <= ATTR_RESET;
            state.pc_breakpoint_space_control  <= 16'h0000;
        end else begin
            state <= next_state;
        end
    end

    assign port_read_data       = state.rdata;
    assign port_read_valid      = state.rvalid;
    assign config_status        = state.cfg;
    assign access_attribute     = state.attr;
    assign attr_trigger         = state.aat;
    assign attr_trigger_second  = state.aat2;
    assign trigger_definition   = state.tdef;
    assign pc_space_control     = state.pc_breakpoint_space_control;
    // Level enables decoded for the comparator side
    assign level1_addr_enabled  = |state.tdef[TD_ADDR_EN_LSB +: 3];
    assign level2_addr_enabled  = |state.tdef[TD_L2_LSB + TD_ADDR_EN_LSB +: 3];
    assign level1_data_enabled  = |state.tdef[TD_DATA_EN_LSB +: 7];
    assign level2_data_enabled  = |state.tdef[TD_L2_LSB + TD_DATA_EN_LSB +: 7];
    assign attr_space_match_en  = state.aat[AAT_SPACE_EN_BIT];
    assign attr2_space_match_en = state.aat2[AAT_SPACE_EN_BIT];
    assign response_select      = state.tdef[TD_RESP_LSB +: 2];

    // Assertions
    a_inhibit_blocks: assert property (@(posedge clock) disable iff (reset)
        core_write && !port_write && state.cfg[CS_INHIBIT_BIT] |=> $stable(trigger_definition)
            && $stable(attr_trigger))
        else $error("inhibited core write changed a register");
    a_tdef_clears_status: assert property (@(posedge clock) disable iff (reset)
        wr && wsel == SEL_TRIG_DEF && !trigger_event |=> config_status[27:24] == 4'h0)
        else $error("status not cleared");
    a_aat_loads_attr: assert property (@(posedge clock) disable iff (reset)
        wr && wsel == SEL_ATTR_TRIG && !mem_command |=> access_attribute == $past(wdata[7:0]))
        else $error("attribute byte not copied");
    a_attr_reset: assert property (@(posedge clock) $fell(reset) |-> access_attribute == 8'h05)
        else $error("attribute reset wrong");
    a_pc_breakpoint_space_control_reset: assert property (@(posedge clock) $fell(reset) |-> pc_space_control == 16'h0000)
        else $error("qualifier reset wrong");
    a_mem_dir: assert property (@(posedge clock) disable iff (reset)
        mem_command |=> access_attribute[7] == $past(mem_is_read) && access_attribute[6:5] == $past(mem_size))
        else $error("direction or size not loaded");
    a_read_zero: assert property (@(posedge clock) disable iff (reset)
        port_read && port_select != SEL_CONFIG_STATUS |=> port_read_valid && port_read_data == 32'h0)
        else $error("write-only register read nonzero");
    a_cfg_write: assert property (@(posedge clock) disable iff (reset)
        port_write && port_select == SEL_CONFIG_STATUS && !trigger_event
            |=> config_status[23:0] == $past(port_data[23:0]))
        else $error("config write lost");
    a_tdef_write: assert property (@(posedge clock) disable iff (reset)
        port_write && port_select == SEL_TRIG_DEF |=> trigger_definition == $past(port_data))
        else $error("trigger definition write lost");

    // Per-register write strobes, read only by the checks below
    logic        wr_cfg;
    logic        wr_pc_breakpoint_space_control;
    logic        wr_attr;
    logic        wr_aat;
    logic        wr_aat2;
    logic        wr_tdef;
    logic        wr_known;

    assign wr_cfg   = wr && (wsel == SEL_CONFIG_STATUS);
    assign wr_pc_breakpoint_space_control  = wr && (wsel == SEL_SPACE_CONTROL);
    assign wr_attr  = wr && (wsel == SEL_ACCESS_ATTR);
    assign wr_aat   = wr && (wsel == SEL_ATTR_TRIG);
    assign wr_aat2  = wr && (wsel == SEL_ATTR_TRIG_2);
    assign wr_tdef  = wr && (wsel == SEL_TRIG_DEF);
    assign wr_known = wr_cfg || wr_pc_breakpoint_space_control || wr_attr || wr_aat || wr_aat2 || wr_tdef;

    // Field positions other than the inhibit bit and the qualifier nibbles are spelled out literally so a wrong constant shows up
    a_core_write_lands: assert property (@(posedge clock) disable iff (reset)
        core_write && !port_write && !state.cfg[CS_INHIBIT_BIT] && core_select == SEL_SPACE_CONTROL
            |=> pc_space_control == $past(core_data[15:0]))
        else $error("permitted core write lost");

    a_inhibit_others: assert property (@(posedge clock) disable iff (reset)
        core_write && !port_write && state.cfg[CS_INHIBIT_BIT] && !mem_command && !trigger_event
            |=> $stable(pc_space_control) && $stable(access_attribute)
                && $stable(attr_trigger_second) && $stable(config_status))
        else $error("inhibited core write was not dropped");

    a_aat_write: assert property (@(posedge clock) disable iff (reset)
        wr_aat |=> attr_trigger == $past(wdata))
        else $error("attribute trigger write lost");

    a_aat2_write: assert property (@(posedge clock) disable iff (reset)
        wr_aat2 |=> attr_trigger_second == $past(wdata))
        else $error("second attribute trigger write lost");

    a_aat2_keeps_attr: assert property (@(posedge clock) disable iff (reset)
        wr_aat2 && !mem_command |=> $stable(access_attribute))
        else $error("second trigger write touched the access attribute");

    a_type_write: assert property (@(posedge clock) disable iff (reset)
        wr_attr && !mem_command |=> access_attribute[4:0] == $past(wdata[4:0])
            && access_attribute[7:5] == $past(access_attribute[7:5]))
        else $error("type and modifier write wrong");

    a_attr_hold: assert property (@(posedge clock) disable iff (reset)
        !mem_command && !wr_attr && !wr_aat |=> $stable(access_attribute))
        else $error("access attribute changed without cause");

    a_status_set_wins: assert property (@(posedge clock) disable iff (reset)
        trigger_event |=> config_status[27:24] == $past(trigger_status_in))
        else $error("status update lost");

    a_status_hold: assert property (@(posedge clock) disable iff (reset)
        !trigger_event && !wr_tdef |=> config_status[27:24] == $past(config_status[27:24]))
        else $error("status changed without cause");

    a_status_hw_only: assert property (@(posedge clock) disable iff (reset)
        wr_cfg && !trigger_event |=> config_status[31:24] == $past(config_status[31:24]))
        else $error("hardware-owned config bits written");

    a_tdef_hold: assert property (@(posedge clock) disable iff (reset)
        !wr_tdef |=> $stable(trigger_definition))
        else $error("trigger definition changed without a write");

    a_read_config: assert property (@(posedge clock) disable iff (reset)
        port_read && port_select == SEL_CONFIG_STATUS
            |=> port_read_valid && port_read_data == $past(config_status))
        else $error("config read returned wrong data");

    a_valid_pulse: assert property (@(posedge clock) disable iff (reset)
        !port_read |=> !port_read_valid)
        else $error("read valid without a read");

    a_read_no_side: assert property (@(posedge clock) disable iff (reset)
        port_read && !wr && !trigger_event && !mem_command
            |=> $stable(config_status) && $stable(access_attribute))
        else $error("port read changed a register");

    // Writes to codes this block does not own must leave every register alone
    a_unknown_ignored: assert property (@(posedge clock) disable iff (reset)
        wr && !wr_known && !trigger_event && !mem_command
            |=> $stable(config_status) && $stable(trigger_definition) && $stable(access_attribute)
                && $stable(pc_space_control) && $stable(attr_trigger) && $stable(attr_trigger_second))
        else $error("write to unknown code changed a register");

    a_reset_clear: assert property (@(posedge clock) $fell(reset) |->
        config_status == 32'h0000_0000 && trigger_definition == 32'h0000_0000
            && attr_trigger == 32'h0000_0000 && attr_trigger_second == 32'h0000_0000)
        else $error("register not cleared by reset");

    a_space_enable: assert property (@(posedge clock) disable iff (reset)
        attr_space_match_en == attr_trigger[31] && attr2_space_match_en == attr_trigger_second[31])
        else $error("space id enable decode wrong");

    a_response_field: assert property (@(posedge clock) disable iff (reset)
        response_select == trigger_definition[31:30])
        else $error("response field decode wrong");

    // One qualifier nibble per PC breakpoint, lowest breakpoint in the low nibble
    logic [PC_QUAL_W-1:0] pc_qual [NUM_PC_BREAKS];
    for (genvar g = 0; g < NUM_PC_BREAKS; g++) begin : g_pc_qual
        assign pc_qual[g] = pc_space_control[g*PC_QUAL_W +: PC_QUAL_W];
        a_qual_reset: assert property (@(posedge clock)
            $fell(reset) |-> pc_qual[g] == 4'h0)
            else $error("qualifier field not cleared by reset");
        a_qual_write: assert property (@(posedge clock) disable iff (reset)
            wr_pc_breakpoint_space_control |=> pc_qual[g] == $past(wdata[g*PC_QUAL_W +: PC_QUAL_W]))
            else $error("qualifier field write lost");
    end

    // Each trigger level owns one half of the definition word
    for (genvar lv = 0; lv < 2; lv++) begin : g_level
        logic [15:0] half;
        logic        addr_en;
        logic        data_en;
        assign half    = trigger_definition[lv*16 +: 16];
        assign addr_en = (lv == 0) ? level1_addr_enabled : level2_addr_enabled;
        assign data_en = (lv == 0) ? level1_data_enabled : level2_data_enabled;
        a_addr_enable: assert property (@(posedge clock) disable iff (reset)
            addr_en == (half[4] || half[3] || half[2]))
            else $error("address enable decode wrong");
        a_data_enable: assert property (@(posedge clock) disable iff (reset)
            data_en == (|half[12:6]))
            else $error("data enable decode wrong");
    end

    c_blocked: cover property (@(posedge clock) core_blocked);
    c_tdef: cover property (@(posedge clock) wr && wsel == SEL_TRIG_DEF);
    c_read: cover property (@(posedge clock) port_read && port_select == SEL_CONFIG_STATUS);
    c_mem: cover property (@(posedge clock) mem_command && mem_is_read);
    c_unknown: cover property (@(posedge clock) wr && !wr_known);

endmodule // dbgbrk_regs

// [test/dbgbrk_host.sv]
/* Model of the external development system on the serial debug port.
   Assumes its tasks are called at falling clock edges. */
`timescale 1ns/1ps
module dbgbrk_host (
    input  wire logic        clock,
    input  wire logic        core_write,
    output logic             port_write,
    output logic             port_read,
    output logic [4:0]       port_select,
    output logic [31:0]      port_data
);
    initial begin
        port_write = 1'b0;
        port_read = 1'b0;
        port_select = 5'h1F;
        port_data = 32'h0;
    end
    task automatic cmd(input logic wr, input logic [4:0] sel, input logic [31:0] d);
        if (core_write) @(negedge clock);
        port_write = wr;
        port_read = !wr;
        port_select = sel;
        port_data = d;
        @(negedge clock);
        port_write = 1'b0;
        port_read = 1'b0;
        // Released lines show junk, not the last value
        port_select = ~sel;
        port_data = ~d;
    endtask
endmodule // dbgbrk_host

// [test/dbgbrk_regs_test.sv]
/* Self-checking bench for the debug register front end.
   Assumes the host model for port commands. */
`timescale 1ns/1ps
module dbgbrk_regs_test;
    import dbgbrk_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        core_write = 1'b0;
    logic [4:0]  core_select = 5'h0;
    logic [31:0] core_data = 32'h0;
    logic        mem_command = 1'b0;
    logic        mem_is_read = 1'b0;
    logic [1:0]  mem_size = 2'h0;
    logic        trigger_event = 1'b0;
    logic [3:0]  trigger_status_in = 4'h0;
    logic        port_write, port_read, port_read_valid;
    logic [4:0]  port_select;
    logic [31:0] port_data, port_read_data, config_status, attr_trigger;
    logic [31:0] attr_trigger_second, trigger_definition;
    logic [7:0]  access_attribute;
    logic [15:0] pc_space_control;
    logic        l1a, l2a, l1d, l2d, sm1, sm2;
    logic [1:0]  response_select;
    int          err_count = 0;
    int          n_compared = 0;
    always #4 clock = ~clock;
    dbgbrk_host i_dbgbrk_host (.clock(clock), .core_write(core_write), .port_write(port_write),
        .port_read(port_read), .port_select(port_select), .port_data(port_data));
    dbgbrk_regs i_dbgbrk_regs (.clock(clock), .reset(reset), .core_write(core_write),
        .core_select(core_select), .core_data(core_data), .port_write(port_write),
        .port_read(port_read), .port_select(port_select), .port_data(port_data),
        .mem_command(mem_command), .mem_is_read(mem_is_read), .mem_size(mem_size),
        .trigger_event(trigger_event), .trigger_status_in(trigger_status_in),
        .port_read_data(port_read_data), .port_read_valid(port_read_valid),
        .config_status(config_status), .access_attribute(access_attribute),
        .attr_trigger(attr_trigger), .attr_trigger_second(attr_trigger_second),
        .trigger_definition(trigger_definition), .pc_space_control(pc_space_control),
        .level1_addr_enabled(l1a), .level2_addr_enabled(l2a), .level1_data_enabled(l1d),
        .level2_data_enabled(l2d), .attr_space_match_en(sm1), .attr2_space_match_en(sm2),
        .response_select(response_select));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic core_wr(input logic [4:0] sel, input logic [31:0] d);
        core_write = 1'b1;
        core_select = sel;
        core_data = d;
        @(negedge clock);
        core_write = 1'b0;
        core_data = ~d;
    endtask
    task automatic pulse_mem(input logic rd, input logic [1:0] sz);
        mem_command = 1'b1;
        mem_is_read = rd;
        mem_size = sz;
        @(negedge clock);
        mem_command = 1'b0;
    endtask
    task automatic t_reset;
        chk({24'h0, access_attribute}, {24'h0, ATTR_RESET});
        chk({16'h0, pc_space_control}, 32'h0);
        chk(trigger_definition, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_tdef;
        logic [31:0] d;
        trigger_status_in = 4'h5;
        trigger_event = 1'b1;
        @(negedge clock);
        trigger_event = 1'b0;
        chk({28'h0, config_status[27:24]}, 32'h5);
        // Triggers off before loading, no interlock
        i_dbgbrk_host.cmd(1'b1, SEL_TRIG_DEF, 32'h0);
        chk({28'h0, config_status[27:24]}, 32'h0);
        for (int r = 0; r < 4; r++) begin
            d = 32'h0004_0040 | (r << 30);
            i_dbgbrk_host.cmd(1'b1, SEL_TRIG_DEF, d);
            chk(trigger_definition, d);
            chk({30'h0, response_select}, r);
            chk({28'h0, l2a, l1a, l2d, l1d}, 32'h9);
        end
        i_dbgbrk_host.cmd(1'b1, SEL_TRIG_DEF, 32'h0);
        $display("t_tdef done");
    endtask
    task automatic t_attr;
        core_wr(SEL_ATTR_TRIG, 32'h80AB_00C3);
        chk(attr_trigger, 32'h80AB_00C3);
        chk({24'h0, access_attribute}, 32'hC3);
        chk({31'h0, sm1}, 32'h1);
        i_dbgbrk_host.cmd(1'b1, SEL_ATTR_TRIG_2, 32'h0012_0000);
        chk(attr_trigger_second, 32'h0012_0000);
        chk({31'h0, sm2}, 32'h0);
        i_dbgbrk_host.cmd(1'b0, SEL_ATTR_TRIG, 32'h0);
        chk(port_read_data, 32'h0);
        i_dbgbrk_host.cmd(1'b1, SEL_ACCESS_ATTR, 32'hFFFF_FF1A);
        chk({24'h0, access_attribute}, 32'hDA);
        pulse_mem(1'b1, 2'h1);
        chk({24'h0, access_attribute}, 32'hBA);
        pulse_mem(1'b0, 2'h2);
        chk({24'h0, access_attribute}, 32'h5A);
        $display("t_attr done");
    endtask
    task automatic t_inhibit;
        i_dbgbrk_host.cmd(1'b1, SEL_CONFIG_STATUS, 32'hFF40_0000);
        chk(config_status, 32'h0040_0000);
        i_dbgbrk_host.cmd(1'b0, SEL_CONFIG_STATUS, 32'h0);
        chk({31'h0, port_read_valid}, 32'h1);
        chk(port_read_data, 32'h0040_0000);
        core_wr(SEL_TRIG_DEF, 32'h1234_0000);
        chk(trigger_definition, 32'h0);
        i_dbgbrk_host.cmd(1'b1, 5'h1F, 32'hFFFF_FFFF);
        chk(trigger_definition, 32'h0);
        chk(config_status, 32'h0040_0000);
        i_dbgbrk_host.cmd(1'b1, SEL_CONFIG_STATUS, 32'h0);
        core_wr(SEL_SPACE_CONTROL, 32'hFFFF_A5C3);
        chk({16'h0, pc_space_control}, 32'hA5C3);
        $display("t_inhibit done");
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        t_reset();
        t_tdef();
        t_attr();
        t_inhibit();
        stop_test();
    end
endmodule // dbgbrk_regs_test
